// ---- verilog/epw_unit.sv ----
// Overview of operation
// - polarity per pair from control bits 1:0
// - period flag sets as each new period starts
// - pins high impedance after reset
// - output configuration from control bits 7:6
// - duty is duty byte plus bits 5:4
// - half-bridge dead band from delay bits 6:0
// - delay bit 7 enables auto-restart
// - period flags at flag bits 1 and 3
// - prescale bits 1:0, run bit 2
// - every reset: inputs and register reset values
// - open-drain register shares legacy timer address
// - all instances share layout and reset values
// - timer control: postscale 6:3, run, prescale
// - open-drain enables in low five bits
// - shutdown held whole period, resumes next
// - source field decode, 000 disables
// - shutdown state 00 low, 01 high, 1x float
// - dead band counted in instruction cycles
`include "epw_consts.svh"
module epw_unit (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic fault_input_pin_n,
    output logic [3:0] bridge_out,
    output logic [3:0] bridge_oe,
    output logic [3:0] bridge_open_drain,
    output logic period_match_flag,
    output logic second_period_match_flag
);
    import epw_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        logic [7:0] unit_control;
        logic [7:0] shutdown_control;
        logic [7:0] restart_and_delay;
        logic [7:0] duty_low_byte;
        logic [7:0] duty_high_byte;
        logic [7:0] open_drain_config;
        logic [7:0] sys_ctrl;
        logic [3:0] pin_direction_bit;
        epw_tb_t tb_a;
        epw_tb_t tb_b;
        logic flag_a;
        logic flag_b;
        logic [1:0] act_pol;
        logic [1:0] act_cfg;
        logic [9:0] act_duty;
        logic act_sd;
        logic [9:0] frac;
        logic pwm_raw;
        logic [6:0] dead_cnt;
        logic [3:0] out_q;
        logic [3:0] oe_q;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] sync_c;
        logic [31:0] rdata;
    } epw_state_t;

    epw_state_t s;
    epw_state_t next_s;

    logic access;
    logic tb_sel;
    logic tb_tick;
    logic period_end;
    logic sd_cause;
    logic sd_evt;
    logic [1:0] pa;
    logic [1:0] pb;
    logic pa_act;
    logic pb_act;
    logic [3:0] act_lvl;
    logic [7:0] wb;
    logic tick_a;
    logic tick_b;
    logic wrap_a;
    logic wrap_b;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign access = psel && penable;
    assign wb = pwdata[7:0];
    assign tb_sel = s.sys_ctrl[`EPW_SYS_TBSEL_BIT];
    assign tb_tick = tb_sel ? tick_b : tick_a;
    assign period_end = tb_sel ? wrap_b : wrap_a;

    // =========================================================
    // timebase helper: prescale 1 for setting 00, else 1/4, by instruction cycle
    function automatic logic presc_done(input logic [7:0] ctrl, input logic [1:0] cnt);
        logic r;
        r = 1'b0;
        unique case (ctrl[`EPW_TC_PS_HI:0])
            2'b00: r = 1'b1;
            2'b01: r = (cnt == 2'h3);
            default: r = (cnt == 2'h3);
        endcase
        return r;
    endfunction

    assign tick_a = s.tb_a.t_ctrl[`EPW_TC_RUN] && presc_done(s.tb_a.t_ctrl, s.tb_a.pre_cnt);
    assign tick_b = s.tb_b.t_ctrl[`EPW_TC_RUN] && presc_done(s.tb_b.t_ctrl, s.tb_b.pre_cnt);
    assign wrap_a = tick_a && (s.tb_a.t_count == s.tb_a.t_period);
    assign wrap_b = tick_b && (s.tb_b.t_count == s.tb_b.t_period);

    // =========================================================
    // shutdown source decode; fault pin is active low
    always_comb begin
        sd_cause = 1'b0;
        if (s.shutdown_control[4] && s.sync_a[2]) begin
            sd_cause = 1'b1;
        end
        if (s.shutdown_control[5] && s.sync_b[2]) begin
            sd_cause = 1'b1;
        end
        if (s.shutdown_control[6] && !s.sync_c[2]) begin
            sd_cause = 1'b1;
        end
    end
    assign sd_evt = sd_cause;

    // =========================================================
    // output stage
    assign pa = s.shutdown_control[`EPW_SD_AC_HI:`EPW_SD_AC_LO];
    assign pb = s.shutdown_control[`EPW_SD_BD_HI:`EPW_SD_BD_LO];
    assign pa_act = ~s.act_pol[`EPW_UC_POL_AC];
    assign pb_act = ~s.act_pol[`EPW_UC_POL_BD];

    always_comb begin
        act_lvl = 4'h0;
        unique case (s.act_cfg)
            EPW_CFG_SINGLE: act_lvl = {1'b0, 1'b0, 1'b0, s.pwm_raw};
            EPW_CFG_FULL_FWD: act_lvl = {s.pwm_raw, 1'b0, 1'b0, 1'b1};
            EPW_CFG_HALF: act_lvl = {1'b0, 1'b0, ~s.pwm_raw & (s.dead_cnt == 7'h00),
                                     s.pwm_raw & (s.dead_cnt == 7'h00)};
            EPW_CFG_FULL_REV: act_lvl = {1'b0, 1'b1, s.pwm_raw, 1'b0};
        endcase
    end

    // =========================================================
    // next-state logic
    always_comb begin
        next_s = s;
        next_s.sync_a = {s.sync_a[1:0], comparator_one};
        next_s.sync_b = {s.sync_b[1:0], comparator_two};
        next_s.sync_c = {s.sync_c[1:0], fault_input_pin_n};

        // timebases: count only while running
        next_s.tb_a.pre_cnt = s.tb_a.t_ctrl[`EPW_TC_RUN] ? s.tb_a.pre_cnt + 2'h1 : 2'h0;
        next_s.tb_b.pre_cnt = s.tb_b.t_ctrl[`EPW_TC_RUN] ? s.tb_b.pre_cnt + 2'h1 : 2'h0;
        if (tick_a) begin
            next_s.tb_a.t_count = wrap_a ? 8'h00 : s.tb_a.t_count + 8'h01;
        end
        if (tick_b) begin
            next_s.tb_b.t_count = wrap_b ? 8'h00 : s.tb_b.t_count + 8'h01;
        end
        if (wrap_a) begin
            next_s.tb_a.post_cnt = s.tb_a.post_cnt + 4'h1;
        end
        if (wrap_b) begin
            next_s.tb_b.post_cnt = s.tb_b.post_cnt + 4'h1;
        end

        // fractional duty counter spans period in quarter units, four per timer tick
        if (tb_tick) begin
            next_s.frac = period_end ? 10'h000 : s.frac + 10'h004;
        end
        next_s.pwm_raw = (s.frac < s.act_duty) && (s.act_cfg != 2'b00 || 1'b1);

        if (s.pwm_raw != next_s.pwm_raw) begin
            next_s.dead_cnt = s.restart_and_delay[`EPW_DEL_CNT_HI:0];
        end else if (s.dead_cnt != 7'h00) begin
            next_s.dead_cnt = s.dead_cnt - 7'h01;
        end

        // period boundary: latch settings and shutdown status
        if (period_end) begin
            next_s.act_pol = s.unit_control[1:0];
            next_s.act_cfg = s.unit_control[`EPW_UC_CFG_HI:`EPW_UC_CFG_LO];
            next_s.act_duty = {s.duty_low_byte,
                               s.unit_control[`EPW_UC_DCL_HI:`EPW_UC_DCL_LO]};
            next_s.duty_high_byte = s.duty_low_byte;
            next_s.act_sd = s.shutdown_control[`EPW_SD_STATUS];
        end

        // postscale counters, cleared on the period match that reaches the postscale setting
        if (wrap_a && s.tb_a.post_cnt == s.tb_a.t_ctrl[`EPW_TC_POST_HI:`EPW_TC_POST_LO]) begin
            next_s.tb_a.post_cnt = 4'h0;
        end
        if (wrap_b && s.tb_b.post_cnt == s.tb_b.t_ctrl[`EPW_TC_POST_HI:`EPW_TC_POST_LO]) begin
            next_s.tb_b.post_cnt = 4'h0;
        end

        // bus writes
        if (access && pwrite) begin
            unique case (paddr)
                `EPW_ADDR_UNIT_CONTROL: next_s.unit_control = wb;
                `EPW_ADDR_SHUTDOWN_CONTROL: begin
                    // status bit write is blocked while a shutdown cause is active
                    next_s.shutdown_control[6:0] = wb[6:0];
                    if (!sd_cause) begin
                        next_s.shutdown_control[`EPW_SD_STATUS] = wb[`EPW_SD_STATUS];
                    end
                end
                `EPW_ADDR_RESTART_DELAY: next_s.restart_and_delay = wb;
                `EPW_ADDR_DUTY_LOW: next_s.duty_low_byte = wb;
                `EPW_ADDR_TBA_COUNT: next_s.tb_a.t_count = wb;
                `EPW_ADDR_TBA_CONTROL: begin
                    if (s.sys_ctrl[`EPW_SYS_ALT_BIT]) begin
                        next_s.open_drain_config = wb & `EPW_OD_MASK;
                    end else begin
                        next_s.tb_a.t_ctrl = wb & `EPW_TC_MASK;
                    end
                end
                `EPW_ADDR_TBA_PERIOD: next_s.tb_a.t_period = wb;
                `EPW_ADDR_TBB_COUNT: next_s.tb_b.t_count = wb;
                `EPW_ADDR_TBB_CONTROL: next_s.tb_b.t_ctrl = wb & `EPW_TC_MASK;
                `EPW_ADDR_TBB_PERIOD: next_s.tb_b.t_period = wb;
                `EPW_ADDR_FLAGS: begin
                    // write one to clear; a same-cycle set still wins below
                    if (wb[`EPW_FLAG_A_BIT]) begin
                        next_s.flag_a = 1'b0;
                    end
                    if (wb[`EPW_FLAG_B_BIT]) begin
                        next_s.flag_b = 1'b0;
                    end
                end
                `EPW_ADDR_PIN_DIR: next_s.pin_direction_bit = wb[3:0];
                `EPW_ADDR_SYS_CTRL: next_s.sys_ctrl = wb;
                default: next_s.sys_ctrl = s.sys_ctrl;
            endcase
        end

        // flag set wins over clear
        if (wrap_a) begin
            next_s.flag_a = 1'b1;
        end
        if (wrap_b) begin
            next_s.flag_b = 1'b1;
        end

        // hardware sets status on event; auto-restart clears it once cause is gone
        if (sd_evt) begin
            next_s.shutdown_control[`EPW_SD_STATUS] = 1'b1;
        end else if (s.restart_and_delay[`EPW_DEL_RESTART] &&
                     s.shutdown_control[`EPW_SD_STATUS] && !sd_cause) begin
            next_s.shutdown_control[`EPW_SD_STATUS] = 1'b0;
        end

        // output drive: shutdown acts at once on event, then holds for a period
        for (int i = 0; i < 4; i++) begin
            logic [1:0] st;
            st = (i == 0 || i == 2) ? pa : pb;
            if (sd_evt || s.act_sd) begin
                next_s.out_q[i] = st[0];
                next_s.oe_q[i] = ~st[1] & ~s.pin_direction_bit[i];
            end else begin
                next_s.out_q[i] = act_lvl[i] ^ ~((i == 0 || i == 2) ? pa_act : pb_act);
                next_s.oe_q[i] = ~s.pin_direction_bit[i];
            end
        end

        // read mux
        next_s.rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `EPW_ADDR_UNIT_CONTROL: next_s.rdata[7:0] = s.unit_control;
                `EPW_ADDR_SHUTDOWN_CONTROL: next_s.rdata[7:0] = s.shutdown_control;
                `EPW_ADDR_RESTART_DELAY: next_s.rdata[7:0] = s.restart_and_delay;
                `EPW_ADDR_DUTY_LOW: next_s.rdata[7:0] = s.duty_low_byte;
                `EPW_ADDR_DUTY_HIGH: next_s.rdata[7:0] = s.duty_high_byte;
                `EPW_ADDR_TBA_COUNT: next_s.rdata[7:0] = s.tb_a.t_count;
                `EPW_ADDR_TBA_CONTROL: next_s.rdata[7:0] = s.sys_ctrl[`EPW_SYS_ALT_BIT] ?
                    s.open_drain_config : s.tb_a.t_ctrl;
                `EPW_ADDR_TBA_PERIOD: next_s.rdata[7:0] = s.tb_a.t_period;
                `EPW_ADDR_TBB_COUNT: next_s.rdata[7:0] = s.tb_b.t_count;
                `EPW_ADDR_TBB_CONTROL: next_s.rdata[7:0] = s.tb_b.t_ctrl;
                `EPW_ADDR_TBB_PERIOD: next_s.rdata[7:0] = s.tb_b.t_period;
                `EPW_ADDR_FLAGS: next_s.rdata[7:0] = {4'h0, s.flag_b, 1'b0, s.flag_a, 1'b0};
                `EPW_ADDR_PIN_DIR: next_s.rdata[7:0] = {4'h0, s.pin_direction_bit};
                `EPW_ADDR_SYS_CTRL: next_s.rdata[7:0] = s.sys_ctrl;
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // registers; every reset restores the same defaults
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.tb_a.t_period <= `EPW_RST_PERIOD;
            s.tb_b.t_period <= `EPW_RST_PERIOD;
            s.pin_direction_bit <= `EPW_RST_DIR;
            s.sync_c <= 3'h7;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign bridge_out = s.out_q;
    assign bridge_oe = s.oe_q;
    assign bridge_open_drain = s.open_drain_config[3:0];
    assign period_match_flag = s.flag_a;
    assign second_period_match_flag = s.flag_b;
endmodule

// ---- verilog/epw_consts.svh ----
`ifndef EPW_CONSTS_SVH
`define EPW_CONSTS_SVH
// register byte addresses, one aligned word each
`define EPW_ADDR_UNIT_CONTROL 12'h000
`define EPW_ADDR_SHUTDOWN_CONTROL 12'h004
`define EPW_ADDR_RESTART_DELAY 12'h008
`define EPW_ADDR_DUTY_LOW 12'h00C
`define EPW_ADDR_DUTY_HIGH 12'h010
`define EPW_ADDR_TBA_COUNT 12'h014
`define EPW_ADDR_TBA_CONTROL 12'h018
`define EPW_ADDR_TBA_PERIOD 12'h01C
`define EPW_ADDR_TBB_COUNT 12'h020
`define EPW_ADDR_TBB_CONTROL 12'h024
`define EPW_ADDR_TBB_PERIOD 12'h028
`define EPW_ADDR_OPEN_DRAIN 12'h02C
`define EPW_ADDR_FLAGS 12'h030
`define EPW_ADDR_PIN_DIR 12'h034
`define EPW_ADDR_SYS_CTRL 12'h038
// field positions
`define EPW_UC_CFG_HI 7
`define EPW_UC_CFG_LO 6
`define EPW_UC_DCL_HI 5
`define EPW_UC_DCL_LO 4
`define EPW_UC_POL_AC 0
`define EPW_UC_POL_BD 1
`define EPW_SD_STATUS 7
`define EPW_SD_SRC_HI 6
`define EPW_SD_SRC_LO 4
`define EPW_SD_AC_HI 3
`define EPW_SD_AC_LO 2
`define EPW_SD_BD_HI 1
`define EPW_SD_BD_LO 0
`define EPW_DEL_RESTART 7
`define EPW_DEL_CNT_HI 6
`define EPW_TC_RUN 2
`define EPW_TC_PS_HI 1
`define EPW_TC_POST_HI 6
`define EPW_TC_POST_LO 3
`define EPW_FLAG_A_BIT 1
`define EPW_FLAG_B_BIT 3
`define EPW_SYS_ALT_BIT 4
`define EPW_SYS_TBSEL_BIT 0
`define EPW_TC_MASK 8'h7F
`define EPW_OD_MASK 8'h1F
`define EPW_RST_BYTE 8'h00
`define EPW_RST_PERIOD 8'hFF
`define EPW_RST_DIR 4'hF
// one instruction cycle is four oscillator periods
`define EPW_TCY_OSC 4
`endif

// ---- verilog/epw_pkg.sv ----
package epw_pkg;
    typedef enum logic [1:0] {
        EPW_CFG_SINGLE = 2'b00,
        EPW_CFG_FULL_FWD = 2'b01,
        EPW_CFG_HALF = 2'b10,
        EPW_CFG_FULL_REV = 2'b11
    } epw_cfg_t;
    typedef enum logic [1:0] {
        EPW_BUS_IDLE = 2'b00,
        EPW_BUS_ACCESS = 2'b01
    } epw_bus_t;
    typedef struct packed {
        logic [7:0] t_count;
        logic [7:0] t_ctrl;
        logic [7:0] t_period;
        logic [1:0] pre_cnt;
        logic [3:0] post_cnt;
    } epw_tb_t;
endpackage

// ---- verif/epw_bridge_model.sv ----
// ==========================================
// bridge switch inputs behind pull-down resistors
module epw_bridge_model (
    input wire logic [3:0] bridge_out,
    input wire logic [3:0] bridge_oe,
    output logic [3:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin is pulled low so its power switch stays off
    assign pin_level = bridge_out & bridge_oe;
endmodule

// ---- verif/epw_unit_checker.sv ----
// ==========================================
// port checks of the pwm unit
module epw_unit_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] bridge_oe,
    input wire logic period_match_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr, rd, alt, run_a;
    logic [3:0] dir;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    // shadows of what software wrote; pready never waits, so each access completes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            alt <= 1'b0;
            run_a <= 1'b0;
            dir <= 4'hF;
        end else if (wr) begin
            if (paddr == 12'h038) alt <= pwdata[4];
            if (paddr == 12'h018 && !alt) run_a <= pwdata[2];
            if (paddr == 12'h034) dir <= pwdata[3:0];
        end
    end
    chk_reset_float: assert property ($fell(sys_rst) |-> bridge_oe == 4'h0)
        else $error("pin driven at reset release");
    chk_input_dir: assert property ((bridge_oe & dir & $past(dir)) == 4'h0)
        else $error("pin driven while set as input");
    chk_no_wait: assert property (psel |-> pready && !pslverr)
        else $error("bus wait or error");
    chk_unmapped_zero: assert property (rd && paddr > 12'h038 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_tc_bit7: assert property (rd && paddr == 12'h018 && !alt |-> !prdata[7])
        else $error("timer control bit 7 set");
    chk_od_upper:
        assert property (rd && paddr == 12'h018 && alt |-> prdata[7:5] == 3'h0)
        else $error("open-drain upper bits set");
    chk_flag_run:
        assert property ($rose(period_match_flag) |-> $past(run_a) || $past(run_a, 3))
        else $error("flag rose with timer stopped");
    chk_flag_clear:
        assert property (wr && paddr == 12'h030 && pwdata[1] && !run_a |=> !period_match_flag)
        else $error("flag not cleared");
    cover property ($rose(period_match_flag));
    cover property ($rose(bridge_oe != 4'h0));
    cover property (rd && paddr == 12'h018 && alt);
endmodule

bind epw_unit epw_unit_checker CHK (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bridge_oe, .period_match_flag
);

// ---- verif/test_enhanced_pwm_startup_config.sv ----
// ==========================================
// start-up, register and shutdown scenarios
module test_enhanced_pwm_startup_config;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic comparator_one = 1'b0, comparator_two = 1'b0, fault_input_pin_n = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, period_match_flag, second_period_match_flag;
    logic [3:0] bridge_out, bridge_oe, bridge_open_drain, lvl;
    int bad_count = 0, num_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    epw_unit DUT (
        .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .comparator_one, .comparator_two, .fault_input_pin_n, .bridge_out,
        .bridge_oe, .bridge_open_drain, .period_match_flag, .second_period_match_flag
    );
    epw_bridge_model PINS (.bridge_out, .bridge_oe, .pin_level(lvl));
    task automatic results;
        if (bad_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ==========================================
    // bus cycles: setup, then access held until pready
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), e, rv);
    endtask
    // clearing first makes the wait end only at a fresh period start
    task automatic wait_flag;
        wr(12'h030, 32'h2);
        for (int i = 0; i < 80 && period_match_flag !== 1'b1; i++) @(posedge sys_clk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset;
        cmp("oe", 32'h0, bridge_oe);
        cmp("pins", 32'h0, lvl);
        for (int i = 0; i < 15; i++) begin
            if (i != 11) begin
                rdc(12'(i * 4), (i == 7 || i == 10) ? 32'hFF : (i == 13) ? 32'hF : 32'h0);
            end
        end
    endtask
    task automatic t_regs;
        wr(12'h000, 32'hFF);
        rdc(12'h000, 32'hFF);
        wr(12'h008, 32'hFF);
        rdc(12'h008, 32'hFF);
        wr(12'h018, 32'hFF);
        rdc(12'h018, 32'h7F);
        wr(12'h038, 32'h10);
        wr(12'h018, 32'hFF);
        rdc(12'h018, 32'h1F);
        cmp("open drain", 32'hF, bridge_open_drain);
        wr(12'h018, 32'h0);
        wr(12'h038, 32'h0);
        rdc(12'h018, 32'h7F);
        wr(12'h03C, 32'hFF);
        rdc(12'h03C, 32'h0);
        wr(12'h018, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h008, 32'h0);
    endtask
    task automatic t_flags;
        wr(12'h030, 32'hA);
        // the count keeps what earlier runs left; above the period it would take a full roll
        wr(12'h014, 32'h0);
        wr(12'h01C, 32'h3);
        wr(12'h018, 32'h5);
        repeat (8) @(posedge sys_clk);
        cmp("flag early", 32'h0, period_match_flag);
        for (int i = 0; i < 80 && period_match_flag !== 1'b1; i++) @(posedge sys_clk);
        rdc(12'h030, 32'h2);
        wr(12'h018, 32'h0);
        wr(12'h030, 32'h2);
        rdc(12'h030, 32'h0);
        wr(12'h028, 32'h3);
        wr(12'h024, 32'h4);
        for (int i = 0; i < 80 && second_period_match_flag !== 1'b1; i++) @(posedge sys_clk);
        cmp("flag b pin", 32'h1, second_period_match_flag);
        rdc(12'h030, 32'h8);
        wr(12'h024, 32'h0);
        wr(12'h030, 32'h8);
        wr(12'h018, 32'h4);
    endtask
    task automatic t_shutdown;
        logic [1:0] ac, bd;
        wr(12'h000, 32'h40);
        for (int i = 0; i < 3; i++) begin
            ac = 2'(i);
            bd = 2'(2 - i);
            wr(12'h004, 32'({1'b1, 3'h0, ac, bd}));
            wait_flag;
            wr(12'h034, 32'h0);
            wait_flag;
            cmp("pins", 32'({bd == 2'h1, ac == 2'h1, bd == 2'h1, ac == 2'h1}), lvl);
            cmp("oe", 32'({!bd[1], !ac[1], !bd[1], !ac[1]}), bridge_oe);
            wr(12'h034, 32'hF);
            wr(12'h004, 32'({4'h0, ac, bd}));
        end
    endtask
    // pins stay inputs here, so the raw output latches are judged
    task automatic t_pwm;
        wr(12'h000, 32'h40);
        wait_flag;
        wait_flag;
        cmp("out fwd", 32'h1, bridge_out);
        wr(12'h00C, 32'hFF);
        wr(12'h000, 32'hF3);
        wait_flag;
        wait_flag;
        cmp("out rev", 32'h9, bridge_out);
        rdc(12'h010, 32'hFF);
        wr(12'h00C, 32'h0);
        wr(12'h000, 32'h80);
        wait_flag;
        wait_flag;
        cmp("out half", 32'h2, bridge_out);
        wr(12'h000, 32'h0);
    endtask
    task automatic t_sources;
        logic [2:0] s;
        logic [31:0] e;
        wr(12'h008, 32'h80);
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 8; j++) begin
                s = 3'(j);
                e = 32'({s[k], s, 4'h0});
                wr(12'h004, 32'({1'b0, s, 4'h0}));
                comparator_one <= (k == 0);
                comparator_two <= (k == 1);
                fault_input_pin_n <= (k != 2);
                repeat (8) @(posedge sys_clk);
                rdc(12'h004, e);
                wr(12'h004, 32'({1'b0, s, 4'h0}));
                rdc(12'h004, e);
                comparator_one <= 1'b0;
                comparator_two <= 1'b0;
                fault_input_pin_n <= 1'b1;
                repeat (8) @(posedge sys_clk);
                rdc(12'h004, 32'({1'b0, s, 4'h0}));
            end
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        results;
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        t_regs;
        t_flags;
        t_shutdown;
        t_pwm;
        t_sources;
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset;
        results;
    end
endmodule
